// >>> hdl/bacr_pkg.sv
// Function
// - hold bit set: memory lines driven high in standby
// - hold bit clear: memory lines float in standby
// - bit 12 keeps row/column strobes driven
// - bit 11 read-only byte order from strap
// - area 0 burst field picks access length
// - area 5 burst field picks burst length
// - area 6 burst field picks burst length
// - areas 2/3 memory type, other codes prohibited
// - bit 1 selects card protocol for area 5
// - bit 0 selects card protocol for area 6
// - size register reset only at power-on
// - reserved size bits read zero, write zero
// - two-bit size field decodes 8/16/32, 00 prohibited
// - idle register power-on reset, read-only bits
// - insert idles on area change or write after read
// - idle code gives one, one, two, three cycles
// - wait-select set: sample wait on clock fall
package bacr_pkg;
   localparam logic [11:0] AMC_OFFSET = 12'h000;
   localparam logic [11:0] ABS_OFFSET = 12'h004;
   localparam logic [11:0] AIC_OFFSET = 12'h008;
   localparam logic [15:0] AMC_RESET = 16'h0000;
   localparam logic [15:0] ABS_RESET = 16'h3ff0;
   localparam logic [15:0] AIC_RESET = 16'h3ff3;
   localparam logic [15:0] AMC_WMASK = 16'hf7ff;
   localparam logic [15:0] ABS_WMASK = 16'h3ff0;
   localparam logic [15:0] AIC_WMASK = 16'hbff3;
   localparam int HOLD_MEM_BIT = 13;
   localparam int HOLD_RC_BIT = 12;
   localparam int ENDIAN_BIT = 11;
   localparam int A0_BURST_POS = 9;
   localparam int A5_BURST_POS = 7;
   localparam int A6_BURST_POS = 5;
   localparam int MEMTYPE_POS = 2;
   localparam int A5_CARD_BIT = 1;
   localparam int A6_CARD_BIT = 0;
   localparam int WAIT_SEL_BIT = 15;
   localparam logic [2:0] MT_BOTH_PLAIN = 3'h0;
   localparam logic [2:0] MT_A3_SYNC = 3'h2;
   localparam logic [2:0] MT_BOTH_SYNC = 3'h3;
   localparam logic [1:0] WIDTH_BAD = 2'h0;
   localparam logic [1:0] WIDTH_8 = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;
   localparam logic [1:0] WIDTH_32 = 2'h3;
   localparam int PIN_SYNC_STAGES = 3;

   // per-area settings latched for the bus cycle engines
   typedef struct packed {
      logic [4:0] burst_len;   // 1 = ordinary, else 4/8/16
      logic [1:0] width_code;  // 01 8-bit, 10 16-bit, 11 32-bit
      logic [1:0] idle_cycles; // 1..3
      logic card_space;        // card protocol selected
      logic sync_dram;         // synchronous dram area
   } bacr_area_cfg_t;

   typedef struct packed {
      logic hold_mem_lines;
      logic hold_row_col;
      logic big_endian_n;
      logic wait_on_fall;
      logic type_prohibited;
      logic width_prohibited;
   } bacr_global_cfg_t;
endpackage

// >>> hdl/bacr_regs.sv
`timescale 1ns/10ps
module bacr_regs
   import bacr_pkg::*;
(
   input wire logic core_clk_i,            // bus clock, 20 MHz
   input wire logic rst_n_i,               // power-on reset, active low
   input wire logic byte_order_strap_i,    // strap pin for byte order
   input wire logic psel_i,                // apb select
   input wire logic penable_i,             // apb enable
   input wire logic pwrite_i,              // apb direction
   input wire logic [11:0] paddr_i,        // apb byte address
   input wire logic [31:0] pwdata_i,       // apb write data
   input wire logic [3:0] pstrb_i,         // apb byte strobes
   output logic pready_o,                  // apb ready
   output logic [31:0] prdata_o,           // apb read data
   output logic pslverr_o,                 // apb error, unmapped
   input wire logic standby_i,             // device in standby
   input wire logic bus_released_i,        // bus granted away
   input wire logic cycle_start_i,         // engine starts a bus cycle
   input wire logic [2:0] cycle_area_i,    // area of starting cycle
   input wire logic cycle_write_i,         // starting cycle is a write
   input wire logic [2:0] area_sel_i,      // area to report in area_cfg_o
   output bacr_area_cfg_t area_cfg_o,      // settings for area_sel_i
   output bacr_global_cfg_t global_cfg_o,  // global settings
   output logic [1:0] idle_insert_o,       // idles due before this cycle
   output logic mem_lines_oe_o,            // drive memory lines
   output logic mem_lines_force_hi_o,      // force memory lines high
   output logic row_col_oe_o,              // drive row/column strobes
   output logic wait_sample_fall_o         // sample wait on falling edge
);
   logic [15:0] amc_ff;
   logic [15:0] abs_ff;
   logic [15:0] aic_ff;
   logic [15:0] shd_amc_ff;
   logic [15:0] shd_abs_ff;
   logic [15:0] shd_aic_ff;
   logic [PIN_SYNC_STAGES-1:0] strap_sync_ff;
   logic [PIN_SYNC_STAGES-1:0] strap_fill_ff;
   logic strap_agree;
   logic strap_taken_ff;
   logic [2:0] last_area_ff;
   logic last_write_ff;
   logic any_cycle_ff;
   logic [1:0] idle_insert_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic wr_en;
   logic rd_en;
   logic hit;

   // two-bit idle code to cycle count
   function automatic logic [1:0] idle_count(input logic [1:0] code);
      unique case (code)
         2'h0, 2'h1: idle_count = 2'h1;
         2'h2: idle_count = 2'h2;
         default: idle_count = 2'h3;
      endcase
   endfunction

   // two-bit burst code to access count
   function automatic logic [4:0] burst_count(input logic [1:0] code);
      unique case (code)
         2'h0: burst_count = 5'h01;
         2'h1: burst_count = 5'h04;
         2'h2: burst_count = 5'h08;
         default: burst_count = 5'h10;
      endcase
   endfunction

   // merge masked write data under byte strobes
   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] wmask);
      logic [15:0] strobed;
      strobed = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
      merge = (old_v & ~(strobed & wmask)) | (pwdata_i[15:0] & strobed & wmask);
   endfunction

   // apb slave answers with no wait states
   assign hit = (paddr_i == AMC_OFFSET) || (paddr_i == ABS_OFFSET) || (paddr_i == AIC_OFFSET);
   assign wr_en = psel_i && penable_i && pwrite_i && hit;
   assign rd_en = psel_i && !penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;
   assign prdata_o = prdata_ff;

   // reserved bits never store, so they always read as zero
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         amc_ff <= AMC_RESET;
         abs_ff <= ABS_RESET;
         aic_ff <= AIC_RESET;
      end
      else if (wr_en)
      begin
         if (paddr_i == AMC_OFFSET)
            amc_ff <= merge(amc_ff, AMC_WMASK);
         if (paddr_i == ABS_OFFSET)
            abs_ff <= merge(abs_ff, ABS_WMASK);
         if (paddr_i == AIC_OFFSET)
            aic_ff <= merge(aic_ff, AIC_WMASK);
      end
   end

   // strap is asynchronous to the bus clock; taken once after reset release
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         strap_sync_ff <= '0;
      else
         strap_sync_ff <= {strap_sync_ff[PIN_SYNC_STAGES-2:0], byte_order_strap_i};
   end

   // fill marker: the reset zeros in the chain must not count as a strap level
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         strap_fill_ff <= '0;
      else
         strap_fill_ff <= {strap_fill_ff[PIN_SYNC_STAGES-2:0], 1'b1};
   end
   assign strap_agree = strap_fill_ff[PIN_SYNC_STAGES-1] && (strap_sync_ff[1] == strap_sync_ff[2]);

   // only a power-on reset recaptures the byte order; read-only to software
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         strap_taken_ff <= 1'b0;
      else if (!strap_taken_ff && strap_agree)
         strap_taken_ff <= 1'b1;
   end

   logic endian_ff;
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         endian_ff <= 1'b0;
      else if (!strap_taken_ff && strap_agree)
         endian_ff <= strap_sync_ff[2];
   end

   // read data latched in setup so it is stable during access
   always_comb
   begin
      nxt_prdata = prdata_ff;
      if (rd_en)
      begin
         if (paddr_i == AMC_OFFSET)
            nxt_prdata = {16'h0000, amc_ff[15:12], endian_ff, amc_ff[10:0]};
         else if (paddr_i == ABS_OFFSET)
            nxt_prdata = {16'h0000, abs_ff & ABS_WMASK};
         else if (paddr_i == AIC_OFFSET)
            nxt_prdata = {16'h0000, aic_ff & AIC_WMASK};
         else
            nxt_prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prdata_ff <= 32'h0000_0000;
      else
         prdata_ff <= nxt_prdata;
   end

   // shadows load only at a cycle start, so a running cycle is undisturbed
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         shd_amc_ff <= AMC_RESET;
         shd_abs_ff <= ABS_RESET;
         shd_aic_ff <= AIC_RESET;
      end
      else if (cycle_start_i)
      begin
         shd_amc_ff <= amc_ff;
         shd_abs_ff <= abs_ff;
         shd_aic_ff <= aic_ff;
      end
   end

   // idle count due: area change or write after read, from the previous area
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         last_area_ff <= 3'h0;
         last_write_ff <= 1'b0;
         any_cycle_ff <= 1'b0;
         idle_insert_ff <= 2'h0;
      end
      else if (cycle_start_i)
      begin
         last_area_ff <= cycle_area_i;
         last_write_ff <= cycle_write_i;
         any_cycle_ff <= 1'b1;
         if (any_cycle_ff && ((cycle_area_i != last_area_ff) ||
             (cycle_write_i && !last_write_ff)))
            idle_insert_ff <= idle_count(aic_field(last_area_ff));
         else
            idle_insert_ff <= 2'h0;
      end
   end
   assign idle_insert_o = idle_insert_ff;

   // idle code of an area; area 1 has none and falls back to area 0
   function automatic logic [1:0] aic_field(input logic [2:0] area);
      logic [3:0] pos;
      pos = (area == 3'h1) ? 4'h0 : {area, 1'b0};
      aic_field = aic_ff[pos +: 2];
   endfunction

   // width code of an area; areas 0 and 1 report 32-bit, set elsewhere
   function automatic logic [1:0] width_field(input logic [2:0] area);
      logic [3:0] pos;
      pos = {area, 1'b0};
      width_field = (area < 3'h2) ? WIDTH_32 : shd_abs_ff[pos +: 2];
   endfunction

   // per-area decode from the shadow copy
   always_comb
   begin
      area_cfg_o = '0;
      area_cfg_o.width_code = width_field(area_sel_i);
      area_cfg_o.idle_cycles = idle_count(shd_aic_ff[(area_sel_i == 3'h1 ? 4'h0 :
         {area_sel_i, 1'b0}) +: 2]);
      area_cfg_o.burst_len = 5'h01;
      unique case (area_sel_i)
         3'h0: area_cfg_o.burst_len = burst_count(shd_amc_ff[A0_BURST_POS +: 2]);
         3'h5:
         begin
            area_cfg_o.burst_len = burst_count(shd_amc_ff[A5_BURST_POS +: 2]);
            area_cfg_o.card_space = shd_amc_ff[A5_CARD_BIT];
         end
         3'h6:
         begin
            area_cfg_o.burst_len = burst_count(shd_amc_ff[A6_BURST_POS +: 2]);
            area_cfg_o.card_space = shd_amc_ff[A6_CARD_BIT];
         end
         3'h2: area_cfg_o.sync_dram = shd_amc_ff[MEMTYPE_POS +: 3] == MT_BOTH_SYNC;
         3'h3: area_cfg_o.sync_dram = (shd_amc_ff[MEMTYPE_POS +: 3] == MT_BOTH_SYNC) ||
            (shd_amc_ff[MEMTYPE_POS +: 3] == MT_A3_SYNC);
         default: area_cfg_o.burst_len = 5'h01;
      endcase
   end

   // global settings, flags for prohibited codes
   always_comb
   begin
      global_cfg_o.hold_mem_lines = amc_ff[HOLD_MEM_BIT];
      global_cfg_o.hold_row_col = amc_ff[HOLD_RC_BIT];
      global_cfg_o.big_endian_n = endian_ff;
      global_cfg_o.wait_on_fall = aic_ff[WAIT_SEL_BIT];
      global_cfg_o.type_prohibited = !((amc_ff[MEMTYPE_POS +: 3] == MT_BOTH_PLAIN) ||
         (amc_ff[MEMTYPE_POS +: 3] == MT_A3_SYNC) ||
         (amc_ff[MEMTYPE_POS +: 3] == MT_BOTH_SYNC));
      global_cfg_o.width_prohibited = (width_field(3'h2) == WIDTH_BAD) ||
         (width_field(3'h3) == WIDTH_BAD) || (width_field(3'h4) == WIDTH_BAD) ||
         (width_field(3'h5) == WIDTH_BAD) || (width_field(3'h6) == WIDTH_BAD);
   end

   // pin control in standby and bus release
   assign mem_lines_oe_o = !standby_i || amc_ff[HOLD_MEM_BIT];
   assign mem_lines_force_hi_o = standby_i && amc_ff[HOLD_MEM_BIT];
   assign row_col_oe_o = !(standby_i || bus_released_i) || amc_ff[HOLD_RC_BIT];
   assign wait_sample_fall_o = aic_ff[WAIT_SEL_BIT];
endmodule

// >>> dv/bacr_regs_chk.sv
`timescale 1ns/10ps
module bacr_regs_chk
   import bacr_pkg::*;
(
   input wire logic core_clk_i, // bus clock
   input wire logic rst_n_i, // reset
   input wire logic psel_i, // select
   input wire logic penable_i, // enable
   input wire logic pwrite_i, // direction
   input wire logic [11:0] paddr_i, // address
   input wire logic [31:0] pwdata_i, // write data
   input wire logic [3:0] pstrb_i, // strobes
   input wire logic pready_o, // ready
   input wire logic [31:0] prdata_o, // read data
   input wire logic pslverr_o, // error
   input wire logic standby_i, // standby
   input wire logic bus_released_i, // bus released
   input wire bacr_global_cfg_t global_cfg_o, // globals
   input wire logic mem_lines_oe_o, // drive memory lines
   input wire logic mem_lines_force_hi_o, // force them high
   input wire logic row_col_oe_o, // drive strobes
   input wire logic wait_sample_fall_o // wait edge
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // access phase and decode, shared by the bus checks
   logic acc;
   logic mapped;
   assign acc = psel_i && penable_i;
   assign mapped = paddr_i inside {AMC_OFFSET, ABS_OFFSET, AIC_OFFSET};
   AST_READY: assert property (acc |-> pready_o) else $error("ready low in access");
   AST_UNMAPPED: assert property (acc |-> pslverr_o == !mapped) else $error("bad error");
   AST_HOLD_HIGH: assert property (standby_i && global_cfg_o.hold_mem_lines
      |-> mem_lines_oe_o && mem_lines_force_hi_o) else $error("lines not held high");
   AST_FLOAT: assert property (standby_i && !global_cfg_o.hold_mem_lines
      |-> !mem_lines_oe_o) else $error("lines not floated");
   AST_ROW_COL: assert property ((standby_i || bus_released_i)
      |-> row_col_oe_o == global_cfg_o.hold_row_col) else $error("strobe drive wrong");
   AST_ENDIAN_RO: assert property (acc && pwrite_i && paddr_i == AMC_OFFSET
      |=> $stable(global_cfg_o.big_endian_n)) else $error("byte order written");
   AST_SIZE_RSVD: assert property (acc && !pwrite_i && paddr_i == ABS_OFFSET
      |-> prdata_o[31:14] == 18'h0 && prdata_o[3:0] == 4'h0) else $error("size rsvd");
   AST_IDLE_RO: assert property (acc && !pwrite_i && paddr_i == AIC_OFFSET
      |-> prdata_o[31:16] == 16'h0 && !prdata_o[14] && !prdata_o[3] && !prdata_o[2])
      else $error("idle rsvd");
   AST_WAIT_SEL: assert property (acc && pwrite_i && paddr_i == AIC_OFFSET && pstrb_i[1]
      |=> wait_sample_fall_o == $past(pwdata_i[WAIT_SEL_BIT])) else $error("wait select");
   cover property (acc && pslverr_o);
   cover property (standby_i && mem_lines_force_hi_o);
   cover property (wait_sample_fall_o);
endmodule

bind bacr_regs bacr_regs_chk u_chk (.*);

// >>> dv/bacr_engine_model.sv
`timescale 1ns/10ps
module bacr_engine_model
(
   input wire logic core_clk_i, // bus clock
   input wire logic rst_n_i, // reset
   input wire logic go_i, // request one bus cycle
   input wire logic [2:0] area_i, // target area
   input wire logic write_i, // direction
   output logic cycle_start_o, // one-cycle start pulse
   output logic [2:0] cycle_area_o, // area of cycle
   output logic cycle_write_o // direction of cycle
);
   // a request becomes one start pulse; area and direction hold until the next one
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cycle_start_o <= 1'h0;
         cycle_area_o <= 3'h0;
         cycle_write_o <= 1'h0;
      end
      else
      begin
         cycle_start_o <= go_i;
         if (go_i)
         begin
            cycle_area_o <= area_i;
            cycle_write_o <= write_i;
         end
      end
   end
endmodule

// >>> dv/bus_area_config_regs_tb.sv
`timescale 1ns/10ps
module bus_area_config_regs_tb;
   import bacr_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic standby = 1'h0, released = 1'h0, go = 1'h0, gw = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [2:0] ga = 3'h0, ca, sel = 3'h0;
   logic [1:0] idle;
   logic pready, pslverr, cs, cw, err, oe, fh, rc, wf;
   bacr_area_cfg_t acfg;
   bacr_global_cfg_t gcfg;
   int fails = 0, n_checks = 0;
   logic [4:0] blen [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
   logic [1:0] iexp [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
   logic [2:0] mts [4] = '{3'h1, 3'h2, 3'h3, 3'h0};
   always #25 clk = ~clk;
   bacr_regs dut (.core_clk_i(clk), .rst_n_i(rst_n), .byte_order_strap_i(1'h1),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(4'hf), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .standby_i(standby), .bus_released_i(released),
      .cycle_start_i(cs), .cycle_area_i(ca), .cycle_write_i(cw), .area_sel_i(sel),
      .area_cfg_o(acfg), .global_cfg_o(gcfg), .idle_insert_o(idle), .mem_lines_oe_o(oe),
      .mem_lines_force_hi_o(fh), .row_col_oe_o(rc), .wait_sample_fall_o(wf));
   bacr_engine_model eng (.core_clk_i(clk), .rst_n_i(rst_n), .go_i(go), .area_i(ga),
      .write_i(gw), .cycle_start_o(cs), .cycle_area_o(ca), .cycle_write_o(cw));
   task automatic complete_run;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; the wait for ready is bounded
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1)
      begin
         fails++;
         complete_run();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // one engine cycle; settings and idle count are settled at the closing fall
   task automatic cyc(input logic [2:0] a, input logic w);
      @(posedge clk);
      go <= 1'h1;
      ga <= a;
      gw <= w;
      @(posedge clk);
      go <= 1'h0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic area(input logic [2:0] a);
      @(posedge clk);
      sel <= a;
      @(negedge clk);
   endtask
   // main sequence: reset, access kinds, decodes, idles, standby
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk);
      rd(AMC_OFFSET, 32'h0800);
      chk(gcfg.big_endian_n, 1'h1);
      rd(ABS_OFFSET, 32'h3ff0);
      rd(AIC_OFFSET, 32'h3ff3);
      apb(1'h1, AMC_OFFSET, 32'h0);
      rd(AMC_OFFSET, 32'h0800);
      apb(1'h1, ABS_OFFSET, 32'hffffffff);
      rd(ABS_OFFSET, 32'h3ff0);
      apb(1'h1, AIC_OFFSET, 32'hffffffff);
      rd(AIC_OFFSET, 32'hbff3);
      chk(wf, 1'h1);
      chk(gcfg.wait_on_fall, 1'h1);
      apb(1'h0, 12'h00c, 32'h0);
      chk(err, 1'h1);
      chk(rdat, 32'h0);
      $display("test access done");
      apb(1'h1, ABS_OFFSET, 32'h17f0);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'h1, AMC_OFFSET, 32'(c * 32'h2a0 + c));
         area(3'h0);
         if (c > 0)
            chk(acfg.burst_len, blen[c - 1]);
         cyc(3'h0, 1'h0);
         area(3'h0);
         chk(acfg.burst_len, blen[c]);
         area(3'h5);
         chk({acfg.burst_len, acfg.card_space}, {blen[c], c[1]});
         area(3'h6);
         chk({acfg.burst_len, acfg.card_space}, {blen[c], c[0]});
      end
      $display("test burst done");
      foreach (mts[i])
      begin
         apb(1'h1, AMC_OFFSET, {27'h0, mts[i], 2'h0});
         cyc(3'h2, 1'h0);
         area(3'h2);
         chk({acfg.sync_dram, gcfg.type_prohibited}, {mts[i] == 3'h3, mts[i] == 3'h1});
         area(3'h3);
         chk(acfg.sync_dram, mts[i] == 3'h3 || mts[i] == 3'h2);
      end
      for (int w = 0; w < 4; w++)
      begin
         apb(1'h1, ABS_OFFSET, 32'h17c0 | 32'(w << 4));
         cyc(3'h2, 1'h0);
         area(3'h2);
         chk({acfg.width_code, gcfg.width_prohibited}, {w[1:0], w == 0});
      end
      area(3'h5);
      chk(acfg.width_code, WIDTH_8);
      $display("test type and width done");
      apb(1'h1, ABS_OFFSET, 32'h3ff0);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'h1, AIC_OFFSET, 32'h3fc3 | 32'(c << 4));
         cyc(3'h2, 1'h0);
         cyc(3'h3, 1'h0);
         chk(idle, iexp[c]);
         area(3'h2);
         chk(acfg.idle_cycles, iexp[c]);
      end
      cyc(3'h3, 1'h0);
      chk(idle, 2'h0);
      cyc(3'h3, 1'h1);
      chk(idle, 2'h3);
      $display("test idle done");
      @(posedge clk);
      standby <= 1'h1;
      released <= 1'h1;
      apb(1'h1, AMC_OFFSET, 32'h2000);
      @(negedge clk);
      chk({oe, fh, rc}, 3'h6);
      apb(1'h1, AMC_OFFSET, 32'h1000);
      @(negedge clk);
      chk({oe, rc}, 2'h1);
      @(posedge clk);
      standby <= 1'h0;
      released <= 1'h0;
      rd(ABS_OFFSET, 32'h3ff0);
      rd(AIC_OFFSET, 32'h3ff3);
      $display("test standby done");
      complete_run();
   end
endmodule
